// *** i2c_ack_sync_arbitration_pkg.sv ***
// constants, field layouts and states shared by the two-wire bus engine
// assumes the link-side logic runs from a 12 ns link clock
package i2c_ack_sync_arbitration_pkg;

    localparam int LINK_CLK_NS = 12;
    localparam int SCL_LOW_NS = 5000;
    localparam int SCL_HIGH_NS = 4000;
    localparam int SDA_HOLD_NS = 300;

    // least times, rounded up to whole link clock cycles
    localparam logic [15:0] SCL_LOW_CYC = 16'((SCL_LOW_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
    localparam logic [15:0] SCL_HIGH_CYC = 16'((SCL_HIGH_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
    localparam logic [15:0] SDA_HOLD_CYC = 16'((SDA_HOLD_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);

    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;

    // status word bit positions
    localparam int ST_GCALL = 7;
    localparam int ST_TEND = 6;
    localparam int ST_STOP = 5;
    localparam int ST_SSEL = 4;
    localparam int ST_MLOST = 3;
    localparam int ST_BUSY = 2;
    localparam int ST_TMODE = 1;
    localparam int ST_RXACK = 0;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] RXD_RST = 8'hff;

    // command word captured on every status write
    localparam int CMD_W = 19;
    localparam int CMD_TX = 0;
    localparam int CMD_ACK = 8;
    localparam int CMD_STOP = 9;
    localparam int CMD_START = 10;
    localparam int CMD_GCEN = 11;
    localparam int CMD_ADDR = 12;

    typedef enum logic [2:0] {
        S_IDLE,
        S_MSTART,
        S_MLOAD,
        S_MXFER,
        S_HOLD,
        S_MSTOP,
        S_SXFER
    } link_state_t;

endpackage : i2c_ack_sync_arbitration_pkg

// *** bit_sync.sv ***
// two-flop synchroniser for independent single-bit levels and toggles
// assumes each bit changes on its own; multi-bit words must not pass here
`timescale 1ns/1ps
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign sync_out = sync_q;

endmodule : bit_sync

// *** i2c_ack_sync_arbitration.sv ***
// two-wire bus engine: acknowledge, clock synchronisation, arbitration, software handshake
// assumes sys_clk and link_clk are unrelated; rst is synchronous to sys_clk;
// the open-drain wires are resolved outside from the *_oe_n outputs
//
// Summary of operation
// RULE_01 - master clocks every acknowledge bit; the transmitter releases data meanwhile
// RULE_02 - receiver acknowledges by holding data low through the acknowledge high phase
// RULE_03 - unmatched slave leaves data high; master then stops or restarts
// RULE_04 - full slave receiver not-acknowledges; master then stops or restarts
// RULE_05 - master receiver withholds last acknowledge; slave transmitter then releases data
// RULE_06 - as master the device drives its own clock onto the clock line
// RULE_07 - data is sampled only while the clock line is high
// RULE_08 - each clock falling edge starts our low count; line held low meanwhile
// RULE_09 - released clock still held low elsewhere: wait, do not count high
// RULE_10 - high period counted once line is high; first finisher pulls low
// RULE_11 - a master transfer starts only while the bus is free
// RULE_12 - sending high but reading low with clock high: release data at once
// RULE_13 - arbitration checks address bits, then data (transmit) or acknowledge (receive)
// RULE_14 - after losing, clocking continues to the end of that byte
// RULE_15 - losing in the address phase switches at once to slave operation
// RULE_16 - a bus event needing service sets the interrupt pending flag
// RULE_17 - clock line held low while an event awaits the status write; the code releases it for stop events and for arbitration lost after the address byte
// RULE_18 - any status write clears the status bits; the code leaves ST_BUSY following the bus
// RULE_19 - start: data falls with clock high; stop: data rises with clock high
// RULE_20 - bytes are eight bits, most significant first, then one acknowledge bit
`timescale 1ns/1ps
module i2c_ack_sync_arbitration (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [6:0] own_addr,
    input wire logic gcall_en,
    input wire logic start_req,
    input wire logic stop_req,
    input wire logic ack_en,
    input wire logic [7:0] tx_data,
    input wire logic status_wr,
    output logic [7:0] bus_status_reg_q,
    output logic interrupt_pending_flag_q,
    output logic [7:0] rx_data_q
);
    localparam int CW = i2c_ack_sync_arbitration_pkg::CMD_W;

    function automatic logic owns_bit(input logic [3:0] b, input logic tm);
        owns_bit = (b == i2c_ack_sync_arbitration_pkg::ACK_BIT) ? !tm : tm;
    endfunction : owns_bit

    function automatic logic cnt_done(input logic [15:0] c, input logic [15:0] lim);
        cnt_done = (c >= lim - 16'h0001);
    endfunction : cnt_done

    // ---------------- sys_clk side ----------------
    logic [CW-1:0] cmd_q, cmd_d;
    logic go_tgl_q, go_tgl_d;
    logic evt_p_q, evt_p_d;
    logic [7:0] status_d, rx_d;
    logic ipf_d, sys_evt, evt_s, busy_s;
    logic [1:0] ssync;

    // ---------------- link_clk side ----------------
    i2c_ack_sync_arbitration_pkg::link_state_t state_q, state_d;
    logic [3:0] lsync;
    logic scl_s, sda_s, go_s, link_rst;
    logic [3:0] bit_q, bit_d;
    logic [15:0] cnt_q, cnt_d;
    logic [7:0] rxsh_q, rxsh_d, txsh_q, txsh_d, rxd_q, rxd_d, evt_sts_q, evt_sts_d;
    logic [CW-1:0] lcmd_q, lcmd_d;
    logic scl_oe_n_q, scl_oe_n_d, sda_oe_n_q, sda_oe_n_d, pin_lo_q;
    logic master_q, master_d, tmode_q, tmode_d, addr_ph_q, addr_ph_d;
    logic lost_q, lost_d, rxack_q, rxack_d, ssel_q, ssel_d, gcall_q, gcall_d;
    logic stop_q, stop_d, busy_q, busy_d, evt_tgl_q, evt_tgl_d;
    logic scl_p_q, sda_p_q, go_p_q;
    logic scl_rise, scl_fall, start_det, stop_det, go, in_xfer, raise, byte_end, hit;

    bit_sync #(.W(2)) u_sys_sync (
        .clk(sys_clk),
        .async_in({busy_q, evt_tgl_q}),
        .sync_out(ssync)
    );

    bit_sync #(.W(4)) u_link_sync (
        .clk(link_clk),
        .async_in({rst, go_tgl_q, sda_in, scl_in}),
        .sync_out(lsync)
    );

    assign evt_s = ssync[0];
    assign busy_s = ssync[1];
    assign scl_s = lsync[0];
    assign sda_s = lsync[1];
    assign go_s = lsync[2];
    assign link_rst = lsync[3];

    // command word is stable from the toggle onward; software spaces its writes
    always_comb begin
        cmd_d = cmd_q;
        go_tgl_d = go_tgl_q;
        if (status_wr) begin
            cmd_d = {own_addr, gcall_en, start_req, stop_req, ack_en, tx_data};
            go_tgl_d = !go_tgl_q;
        end
        sys_evt = evt_s ^ evt_p_q;
        evt_p_d = evt_s;
        status_d = status_wr ? i2c_ack_sync_arbitration_pkg::STATUS_RST : bus_status_reg_q; // RULE_18
        if (sys_evt) begin
            status_d = status_d | evt_sts_q; // RULE_18
        end
        status_d[i2c_ack_sync_arbitration_pkg::ST_BUSY] = busy_s;
        ipf_d = sys_evt | (interrupt_pending_flag_q & !status_wr); // RULE_16
        rx_d = sys_evt ? rxd_q : rx_data_q;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmd_q <= '0;
            go_tgl_q <= 1'b0;
            evt_p_q <= 1'b0;
            bus_status_reg_q <= i2c_ack_sync_arbitration_pkg::STATUS_RST;
            interrupt_pending_flag_q <= 1'b0;
            rx_data_q <= i2c_ack_sync_arbitration_pkg::RXD_RST;
        end else begin
            cmd_q <= cmd_d;
            go_tgl_q <= go_tgl_d;
            evt_p_q <= evt_p_d;
            bus_status_reg_q <= status_d;
            interrupt_pending_flag_q <= ipf_d;
            rx_data_q <= rx_d;
        end
    end

    // ---------------- link engine ----------------
    assign scl_rise = scl_s & !scl_p_q;
    assign scl_fall = !scl_s & scl_p_q;
    assign start_det = scl_s & scl_p_q & sda_p_q & !sda_s; // RULE_19
    assign stop_det = scl_s & scl_p_q & !sda_p_q & sda_s; // RULE_19
    assign go = go_s ^ go_p_q;
    assign in_xfer = (state_q == i2c_ack_sync_arbitration_pkg::S_MXFER) ||
                     (state_q == i2c_ack_sync_arbitration_pkg::S_SXFER);

    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        cnt_d = cnt_q;
        rxsh_d = rxsh_q;
        txsh_d = txsh_q;
        rxd_d = rxd_q;
        scl_oe_n_d = scl_oe_n_q;
        sda_oe_n_d = sda_oe_n_q;
        master_d = master_q;
        tmode_d = tmode_q;
        addr_ph_d = addr_ph_q;
        lost_d = lost_q;
        rxack_d = rxack_q;
        ssel_d = ssel_q;
        gcall_d = gcall_q;
        stop_d = stop_q;
        busy_d = busy_q;
        lcmd_d = go ? cmd_q : lcmd_q;
        evt_sts_d = evt_sts_q;
        raise = 1'b0;
        byte_end = 1'b0;
        hit = 1'b0;
        case (state_q)
            i2c_ack_sync_arbitration_pkg::S_IDLE: begin
                // a start asked for while the bus is busy is dropped
                if (go && cmd_q[i2c_ack_sync_arbitration_pkg::CMD_START] && !busy_q) begin // RULE_11
                    txsh_d = cmd_q[i2c_ack_sync_arbitration_pkg::CMD_TX +: 8];
                    cnt_d = 16'h0000;
                    state_d = i2c_ack_sync_arbitration_pkg::S_MSTART;
                end
            end
            i2c_ack_sync_arbitration_pkg::S_MSTART: begin
                if (!scl_oe_n_q) begin
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_done(cnt_q, i2c_ack_sync_arbitration_pkg::SCL_LOW_CYC)) begin
                        scl_oe_n_d = 1'b1;
                        cnt_d = 16'h0000;
                    end
                end else if (!scl_s) begin
                    cnt_d = 16'h0000;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_done(cnt_q, i2c_ack_sync_arbitration_pkg::SCL_HIGH_CYC)) begin
                        cnt_d = 16'h0000;
                        if (sda_oe_n_q) begin
                            sda_oe_n_d = 1'b0; // RULE_19
                        end else begin
                            scl_oe_n_d = 1'b0; // RULE_06
                            master_d = 1'b1;
                            addr_ph_d = 1'b1;
                            tmode_d = 1'b1;
                            lost_d = 1'b0;
                            bit_d = 4'h0;
                            state_d = i2c_ack_sync_arbitration_pkg::S_MLOAD;
                        end
                    end
                end
            end
            i2c_ack_sync_arbitration_pkg::S_MLOAD: begin
                // data changes only after the hold time into the low phase
                cnt_d = cnt_q + 16'h0001;
                if (cnt_done(cnt_q, i2c_ack_sync_arbitration_pkg::SDA_HOLD_CYC)) begin
                    sda_oe_n_d = !(tmode_q && !txsh_q[7]); // RULE_20
                    state_d = i2c_ack_sync_arbitration_pkg::S_MXFER;
                end
            end
            i2c_ack_sync_arbitration_pkg::S_MXFER: begin
                if (!scl_oe_n_q) begin
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_done(cnt_q, i2c_ack_sync_arbitration_pkg::SCL_LOW_CYC)) begin // RULE_08
                        scl_oe_n_d = 1'b1;
                        cnt_d = 16'h0000;
                    end
                end else if (!scl_s) begin
                    cnt_d = 16'h0000; // RULE_09
                    if (scl_fall) begin
                        scl_oe_n_d = 1'b0; // RULE_08
                    end
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_done(cnt_q, i2c_ack_sync_arbitration_pkg::SCL_HIGH_CYC)) begin // RULE_10
                        scl_oe_n_d = 1'b0; // RULE_06
                        cnt_d = 16'h0000;
                    end
                end
            end
            i2c_ack_sync_arbitration_pkg::S_HOLD: begin
                scl_oe_n_d = 1'b0; // RULE_17
                cnt_d = 16'h0000;
                if (go) begin
                    txsh_d = cmd_q[i2c_ack_sync_arbitration_pkg::CMD_TX +: 8];
                    if (!master_q) begin
                        sda_oe_n_d = !(tmode_q && !cmd_q[i2c_ack_sync_arbitration_pkg::CMD_TX + 7]);
                        scl_oe_n_d = 1'b1;
                        state_d = i2c_ack_sync_arbitration_pkg::S_SXFER;
                    end else if (cmd_q[i2c_ack_sync_arbitration_pkg::CMD_START]) begin
                        state_d = i2c_ack_sync_arbitration_pkg::S_MSTART; // RULE_03 RULE_04
                    end else if (cmd_q[i2c_ack_sync_arbitration_pkg::CMD_STOP]) begin
                        state_d = i2c_ack_sync_arbitration_pkg::S_MSTOP; // RULE_03 RULE_04
                    end else begin
                        state_d = i2c_ack_sync_arbitration_pkg::S_MLOAD;
                    end
                end
            end
            i2c_ack_sync_arbitration_pkg::S_MSTOP: begin
                // the state is left when the stop is seen on the wires
                if (!scl_oe_n_q) begin
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_done(cnt_q, i2c_ack_sync_arbitration_pkg::SDA_HOLD_CYC)) begin
                        sda_oe_n_d = 1'b0;
                    end
                    if (cnt_done(cnt_q, i2c_ack_sync_arbitration_pkg::SCL_LOW_CYC)) begin
                        scl_oe_n_d = 1'b1;
                        cnt_d = 16'h0000;
                    end
                end else if (!scl_s) begin
                    cnt_d = 16'h0000; // RULE_09
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_done(cnt_q, i2c_ack_sync_arbitration_pkg::SCL_HIGH_CYC)) begin
                        sda_oe_n_d = 1'b1; // RULE_19
                    end
                end
            end
            i2c_ack_sync_arbitration_pkg::S_SXFER: begin
                scl_oe_n_d = 1'b1;
            end
            default: begin
                state_d = i2c_ack_sync_arbitration_pkg::S_IDLE;
            end
        endcase

        if (in_xfer && scl_rise) begin
            rxsh_d = {rxsh_q[6:0], sda_s}; // RULE_07 RULE_20
            if (bit_q == i2c_ack_sync_arbitration_pkg::ACK_BIT && tmode_q) begin
                rxack_d = !sda_s;
            end
            if (master_q && !lost_q && sda_oe_n_q && !sda_s && owns_bit(bit_q, tmode_q)) begin // RULE_13
                lost_d = 1'b1;
                sda_oe_n_d = 1'b1; // RULE_12
                if (addr_ph_q) begin
                    master_d = 1'b0; // RULE_15
                    tmode_d = 1'b0;
                    scl_oe_n_d = 1'b1;
                    state_d = i2c_ack_sync_arbitration_pkg::S_SXFER;
                end
            end
        end

        if (in_xfer && scl_fall) begin
            if (bit_q < i2c_ack_sync_arbitration_pkg::LAST_DATA_BIT) begin
                bit_d = bit_q + 4'h1;
                txsh_d = {txsh_q[6:0], 1'b0}; // RULE_20
                sda_oe_n_d = !(owns_bit(bit_d, tmode_q) && !lost_q && !txsh_q[6]); // RULE_12
            end else if (bit_q == i2c_ack_sync_arbitration_pkg::LAST_DATA_BIT) begin
                bit_d = i2c_ack_sync_arbitration_pkg::ACK_BIT; // RULE_20
                rxd_d = rxsh_q;
                if (addr_ph_q && !master_q) begin
                    hit = (rxsh_q[7:1] == lcmd_q[i2c_ack_sync_arbitration_pkg::CMD_ADDR +: 7]) ||
                          (rxsh_q[7:1] == 7'h00 && lcmd_q[i2c_ack_sync_arbitration_pkg::CMD_GCEN]);
                    ssel_d = hit;
                    gcall_d = hit && (rxsh_q[7:1] == 7'h00);
                    sda_oe_n_d = !hit; // RULE_02 RULE_03
                    if (!hit) begin
                        state_d = i2c_ack_sync_arbitration_pkg::S_IDLE;
                    end
                end else begin
                    // transmitter releases; receiver acks only if software allows it
                    sda_oe_n_d = !(!tmode_q && !lost_q &&
                                   lcmd_q[i2c_ack_sync_arbitration_pkg::CMD_ACK]); // RULE_01 RULE_02 RULE_04 RULE_05
                end
            end else begin
                bit_d = 4'h0;
                byte_end = 1'b1;
                sda_oe_n_d = 1'b1; // RULE_01
                addr_ph_d = 1'b0;
                if (addr_ph_q) begin
                    tmode_d = master_q ? !rxd_q[0] : rxd_q[0];
                end
                if (lost_q && master_q) begin
                    master_d = 1'b0; // RULE_14
                    scl_oe_n_d = 1'b1;
                    state_d = i2c_ack_sync_arbitration_pkg::S_IDLE;
                    raise = 1'b1;
                end else if (!master_q && tmode_q && !addr_ph_q && !rxack_q) begin
                    state_d = i2c_ack_sync_arbitration_pkg::S_IDLE; // RULE_05
                end else begin
                    scl_oe_n_d = 1'b0; // RULE_17
                    cnt_d = 16'h0000;
                    state_d = i2c_ack_sync_arbitration_pkg::S_HOLD;
                    raise = 1'b1; // RULE_16
                end
            end
        end

        if (start_det) begin
            busy_d = 1'b1;
            stop_d = 1'b0;
            if (!master_q && state_q != i2c_ack_sync_arbitration_pkg::S_MSTART) begin
                state_d = i2c_ack_sync_arbitration_pkg::S_SXFER;
                addr_ph_d = 1'b1;
                tmode_d = 1'b0;
                bit_d = 4'h0;
                ssel_d = 1'b0;
                gcall_d = 1'b0;
                scl_oe_n_d = 1'b1;
                sda_oe_n_d = 1'b1;
            end
        end
        if (stop_det) begin
            busy_d = 1'b0;
            stop_d = 1'b1;
            raise = master_q || ssel_q;
            master_d = 1'b0;
            ssel_d = 1'b0;
            addr_ph_d = 1'b0;
            scl_oe_n_d = 1'b1;
            sda_oe_n_d = 1'b1;
            state_d = i2c_ack_sync_arbitration_pkg::S_IDLE;
        end

        evt_tgl_d = evt_tgl_q ^ raise;
        if (raise) begin
            evt_sts_d[i2c_ack_sync_arbitration_pkg::ST_GCALL] = gcall_d;
            evt_sts_d[i2c_ack_sync_arbitration_pkg::ST_TEND] = byte_end;
            evt_sts_d[i2c_ack_sync_arbitration_pkg::ST_STOP] = stop_d;
            evt_sts_d[i2c_ack_sync_arbitration_pkg::ST_SSEL] = ssel_d;
            evt_sts_d[i2c_ack_sync_arbitration_pkg::ST_MLOST] = lost_d;
            evt_sts_d[i2c_ack_sync_arbitration_pkg::ST_BUSY] = busy_d;
            evt_sts_d[i2c_ack_sync_arbitration_pkg::ST_TMODE] = tmode_d;
            evt_sts_d[i2c_ack_sync_arbitration_pkg::ST_RXACK] = rxack_d;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            state_q <= i2c_ack_sync_arbitration_pkg::S_IDLE;
            bit_q <= 4'h0;
            cnt_q <= 16'h0000;
            rxsh_q <= 8'h00;
            txsh_q <= 8'h00;
            rxd_q <= i2c_ack_sync_arbitration_pkg::RXD_RST;
            evt_sts_q <= i2c_ack_sync_arbitration_pkg::STATUS_RST;
            lcmd_q <= '0;
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
            {master_q, tmode_q, addr_ph_q, lost_q, rxack_q} <= 5'h00;
            {ssel_q, gcall_q, stop_q, busy_q, evt_tgl_q} <= 5'h00;
            {scl_p_q, sda_p_q, go_p_q} <= 3'h6;
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            cnt_q <= cnt_d;
            rxsh_q <= rxsh_d;
            txsh_q <= txsh_d;
            rxd_q <= rxd_d;
            evt_sts_q <= evt_sts_d;
            lcmd_q <= lcmd_d;
            scl_oe_n_q <= scl_oe_n_d;
            sda_oe_n_q <= sda_oe_n_d;
            {master_q, tmode_q, addr_ph_q, lost_q, rxack_q} <=
                {master_d, tmode_d, addr_ph_d, lost_d, rxack_d};
            {ssel_q, gcall_q, stop_q, busy_q, evt_tgl_q} <=
                {ssel_d, gcall_d, stop_d, busy_d, evt_tgl_d};
            {scl_p_q, sda_p_q, go_p_q} <= {scl_s, sda_s, go_s};
        end
        pin_lo_q <= 1'b0;
    end

    assign scl_out = pin_lo_q;
    assign sda_out = pin_lo_q;
    assign scl_oe_n = scl_oe_n_q;
    assign sda_oe_n = sda_oe_n_q;

endmodule : i2c_ack_sync_arbitration

// *** i2c_ack_sync_arbitration_checker.sv ***
// port assertions for the two-wire bus engine
// assumes the wires are resolved outside from the *_oe_n outputs
`timescale 1ns/1ps
module i2c_ack_sync_arbitration_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe_n,
    input wire logic sda_out,
    input wire logic status_wr,
    input wire logic [7:0] bus_status_reg_q,
    input wire logic interrupt_pending_flag_q
);
    // saturating run lengths of the raw clock wire, low and high
    logic [15:0] lo_q, lo_d, hi_q, hi_d;
    always_comb begin
        lo_d = (rst || scl_in) ? 16'h0000 : lo_q + {15'h0000, ~&lo_q};
        hi_d = (rst || !scl_in) ? 16'h0000 : hi_q + {15'h0000, ~&hi_q};
    end
    always_ff @(posedge link_clk) begin
        lo_q <= lo_d;
        hi_q <= hi_d;
    end
    a_low_time: assert property (@(posedge link_clk) disable iff (rst)
        $rose(scl_oe_n) |-> lo_q >= i2c_ack_sync_arbitration_pkg::SCL_LOW_CYC)
        else $error("clock released before its low time");
    a_high_time: assert property (@(posedge link_clk) disable iff (rst)
        $fell(scl_oe_n) && $past(scl_in) |-> hi_q >= i2c_ack_sync_arbitration_pkg::SCL_HIGH_CYC)
        else $error("clock pulled low before its high time");
    a_open_drain: assert property (@(posedge link_clk) disable iff (rst)
        scl_out == 1'b0 && sda_out == 1'b0) else $error("wire driven high");
    // an event landing with the write wins, so flag and bits may be set again
    a_status_clear: assert property (@(posedge sys_clk) disable iff (rst)
        status_wr |=> interrupt_pending_flag_q || (bus_status_reg_q & 8'hfb) == 8'h00)
        else $error("status not cleared");
    a_flag_clear: assert property (@(posedge sys_clk) disable iff (rst)
        status_wr |=> !interrupt_pending_flag_q || bus_status_reg_q[7:3] != 5'h00)
        else $error("flag not cleared by write");
    a_bits_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        |($past(bus_status_reg_q[7:3]) & ~bus_status_reg_q[7:3]) |-> $past(status_wr))
        else $error("status bit dropped without write");
    a_flag_cause: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(interrupt_pending_flag_q) |-> ##[0:1] (bus_status_reg_q[7:3] != 5'h00))
        else $error("flag raised without status event");
    a_flag_holds: assert property (@(posedge sys_clk) disable iff (rst)
        interrupt_pending_flag_q && bus_status_reg_q[6] && !bus_status_reg_q[3] |-> !scl_oe_n)
        else $error("clock not held while event pending");
endmodule : i2c_ack_sync_arbitration_checker
bind i2c_ack_sync_arbitration i2c_ack_sync_arbitration_checker i_chk (.sys_clk, .rst,
    .link_clk, .scl_in, .scl_out, .scl_oe_n, .sda_out, .status_wr, .bus_status_reg_q,
    .interrupt_pending_flag_q);

// *** bus_slave_model.sv ***
// behavioural slave on the two-wire bus: takes bytes, acknowledges its address
// assumes the bench resolves both wires with pull-ups and feeds them back
`timescale 1ns/1ps
module bus_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a,
    parameter int STRETCH_NS = 20000
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic stretch_en,
    output logic scl_rel = 1'b1,
    output logic sda_rel = 1'b1,
    output logic [7:0] last_byte = 8'h00
);
    int cnt = 0;
    logic first = 1'b0;
    logic sel = 1'b0;
    logic [7:0] sh = 8'h00;
    always @(negedge sda) if (scl) begin cnt = 0; first = 1'b1; end
    always @(posedge sda) if (scl) sel = 1'b0;
    always @(posedge scl) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        cnt = (cnt == 8) ? 0 : cnt + 1;
    end
    always @(negedge scl) begin
        if (cnt == 8) begin
            if (first) sel = (sh[7:1] == ADDR);
            first = 1'b0;
            last_byte = sh;
            sda_rel = !sel;
        end else if (cnt == 0) begin
            sda_rel = 1'b1;
            // a stretched low phase forces the master to wait high
            if (stretch_en && sel) begin scl_rel = 1'b0; #(STRETCH_NS); scl_rel = 1'b1; end
        end
    end
endmodule : bus_slave_model

// *** i2c_ack_sync_arbitration_test.sv ***
// self-checking bench: the engine as master against one slave model
// assumes open-drain wires with pull-ups, resolved here from all enables
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module i2c_ack_sync_arbitration_test;
    logic sys_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, status_wr = 1'b0, start_req = 1'b0;
    logic stop_req = 1'b0, ack_en = 1'b0, stretch_en = 1'b0, flag;
    logic [7:0] tx_data = 8'h00, st, rxd, last_byte;
    logic scl_oe_n, sda_oe_n, scl_rel, sda_rel;
    wire logic scl = scl_oe_n & scl_rel;
    wire logic sda = sda_oe_n & sda_rel;
    int fails = 0, checks = 0, cycles = 0;
    initial forever #12.5 sys_clk = ~sys_clk;
    initial begin #3; forever #6 link_clk = ~link_clk; end
    i2c_ack_sync_arbitration i_i2c_ack_sync_arbitration (.sys_clk(sys_clk), .rst(rst),
        .link_clk(link_clk), .scl_in(scl), .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda),
        .sda_out(), .sda_oe_n(sda_oe_n), .own_addr(7'h55), .gcall_en(1'b0),
        .start_req(start_req), .stop_req(stop_req), .ack_en(ack_en), .tx_data(tx_data),
        .status_wr(status_wr), .bus_status_reg_q(st), .interrupt_pending_flag_q(flag),
        .rx_data_q(rxd));
    bus_slave_model i_bus_slave_model (.scl(scl), .sda(sda), .stretch_en(stretch_en),
        .scl_rel(scl_rel), .sda_rel(sda_rel), .last_byte(last_byte));
    task summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task wr(input logic s, input logic p, input logic [7:0] d);
        @(posedge sys_clk);
        status_wr <= 1'b1;
        start_req <= s;
        stop_req <= p;
        ack_en <= 1'b1;
        tx_data <= d;
        @(posedge sys_clk);
        status_wr <= 1'b0;
        @(posedge sys_clk);
        `CHK("flag after write", 1'b0, flag)
        `CHK("status after write", 8'h00, st & 8'hfb)
        repeat (3) @(posedge sys_clk);
    endtask : wr
    task wait_flag;
        int n;
        n = 0;
        while (flag !== 1'b1 && n < 20000) begin @(posedge sys_clk); n++; end
        `CHK("event flag", 1'b1, flag)
    endtask : wait_flag
    // one byte as master transmitter, s asks for a (repeated) start first
    task xfer(input logic s, input logic [7:0] d, input logic ack);
        wr(s, 1'b0, d);
        wait_flag;
        `CHK("byte end", 1'b1, st[6])
        `CHK("ack seen", ack, st[0])
        `CHK("mode bits", 4'h3, st[4:1])
        `CHK("clock held", 1'b0, scl_oe_n)
        `CHK("byte at slave", d, last_byte)
        `CHK("sampled byte", d, rxd)
    endtask : xfer
    task stop_bus;
        wr(1'b0, 1'b1, 8'h00);
        wait_flag;
        `CHK("stop seen", 1'b1, st[5])
        `CHK("bits after stop", 4'h0, {st[6], st[4:2]})
        `CHK("wires idle", 2'b11, {scl, sda})
    endtask : stop_bus
    task t_write;
        xfer(1'b1, 8'h54, 1'b1);
        xfer(1'b0, 8'ha5, 1'b1);
        stop_bus;
    endtask : t_write
    task t_nack_restart;
        xfer(1'b1, 8'h2a, 1'b0);
        xfer(1'b1, 8'h54, 1'b1);
        stop_bus;
    endtask : t_nack_restart
    task t_stretch;
        stretch_en <= 1'b1;
        xfer(1'b1, 8'h54, 1'b1);
        xfer(1'b0, 8'h3c, 1'b1);
        stop_bus;
        stretch_en <= 1'b0;
    endtask : t_stretch
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin fails++; summarize; end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_write;
        t_nack_restart;
        t_stretch;
        summarize;
    end
endmodule : i2c_ack_sync_arbitration_test
